// ===== hdl/msc_pkg.sv
// Package for the modulator carrier-select block: register offsets, field positions, reset values, types.
// Assumes a 32-bit APB slave with one aligned word per byte-wide register.
`default_nettype none
package msc_pkg;
  // Register byte offsets
  localparam logic [11:0] MSC_OFF_CARH = 12'h000; // High carrier control
  localparam logic [11:0] MSC_OFF_CARL = 12'h004; // Low carrier control
  localparam logic [11:0] MSC_OFF_CON = 12'h008; // Modulation control
  localparam logic [11:0] MSC_OFF_SRC = 12'h00C; // Modulation source select
  // Carrier register fields
  localparam int MSC_CAR_ODIS = 7; // Pin disable
  localparam int MSC_CAR_POL = 6; // Invert
  localparam int MSC_CAR_SYNC = 5; // Falling-edge sync
  // Control register fields
  localparam int MSC_CON_EN = 7; // Module enable
  localparam int MSC_CON_OE = 6; // Pin output enable
  localparam int MSC_CON_SLR = 5; // Slew limit
  localparam int MSC_CON_OPOL = 4; // Output invert
  localparam int MSC_CON_OUT = 3; // Read-only output value
  localparam int MSC_CON_BIT = 0; // Software modulation bit
  localparam int MSC_SRC_ODIS = 7; // Source pin disable
  // Carrier select codes
  localparam logic [3:0] MSC_SEL_VSS = 4'h0; // Ground
  localparam logic [3:0] MSC_SEL_PIN1 = 4'h1; // First carrier pin
  localparam logic [3:0] MSC_SEL_PIN2 = 4'h2; // Second carrier pin (high only)
  localparam logic [3:0] MSC_SEL_REFCLK = 4'h3; // Reference clock
  localparam logic [3:0] MSC_SEL_PWM = 4'h4; // Capture/compare PWM output
  // Modulation source codes
  localparam logic [3:0] MSC_MS_SWBIT = 4'h0; // Software bit
  localparam logic [3:0] MSC_MS_PIN = 4'h1; // Modulation pin
  localparam logic [3:0] MSC_MS_PWM = 4'h2; // PWM output
  localparam logic [3:0] MSC_MS_CMP = 4'h6; // Comparator output
  localparam logic [3:0] MSC_MS_SDO = 4'h8; // Serial data out
  localparam logic [3:0] MSC_MS_TX = 4'hA; // UART transmit
  // Reset values: control register clears except slew limit; carriers chosen as zero
  localparam logic [7:0] MSC_CON_RST = 8'h20;
  localparam logic [7:0] MSC_CAR_RST = 8'h00;
  localparam logic [7:0] MSC_SRC_RST = 8'h00;
  // Carrier register: disable, invert, sync, select
  typedef struct packed {
    logic odis;
    logic pol;
    logic sync;
    logic [3:0] sel;
  } msc_car_t;
  // Control register writable fields
  typedef struct packed {
    logic en;
    logic oe;
    logic slr;
    logic opol;
    logic swbit;
  } msc_con_t;
  // Modulation source register
  typedef struct packed {
    logic odis;
    logic [3:0] sel;
  } msc_src_t;
  // Raw sources that feed the block, all from other clock domains or pins
  typedef struct packed {
    logic pin1;
    logic pin2;
    logic refclk;
    logic pwm;
    logic mod_pin;
    logic cmp;
    logic sdo;
    logic tx;
  } msc_src_in_t;
endpackage
`default_nettype wire

// ===== hdl/msc_sync3.sv
// Three-stage synchroniser; a change is accepted once stages two and three agree.
// Assumes an asynchronous input level and the block clock.
`default_nettype none
module msc_sync3 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  // All state in one vector: three stages then accepted value
  typedef struct packed {
    logic [2:0] s;
    logic v;
  } msc_sy_t;
  msc_sy_t st_q, st_d;

  // Next state; stage one feeds only stage two
  always_comb begin
    st_d = st_q;
    st_d.s = {st_q.s[1:0], din};
    if (st_q.s[1] == st_q.s[2]) begin
      st_d.v = st_q.s[2]; // Stable over two samples
    end
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.v;
endmodule // msc_sync3

// ===== hdl/msc_top.sv
// Modulator carrier-select block: APB registers, carrier muxing, sync switching, output path.
// Assumes carrier and modulation sources arrive asynchronously; pin drivers are outside.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`default_nettype none
module msc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic porn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire msc_pkg::msc_src_in_t src_in,
  output logic modulated_out,
  output logic modulator_pin_enable,
  output logic output_slew_limit,
  output logic [4:0] hi_pin_block,
  output logic [4:0] lo_pin_block,
  output logic [7:0] mod_pin_block
);
  // Synchronised sources; a net, since every bit has a driver of its own
  wire msc_pkg::msc_src_in_t src_s;

  // One synchroniser per source bit
  for (genvar i = 0; i < 8; i++) begin : g_sync
    msc_sync3 u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din(src_in[i]),
      .dout(src_s[i])
    );
  end

  // All block state
  typedef struct packed {
    msc_pkg::msc_car_t carh;
    msc_pkg::msc_car_t carl;
    msc_pkg::msc_src_t src;
    msc_pkg::msc_con_t con;
    logic use_high; // Path now driving the output
    logic hi_prev; // Previous high carrier, for edge detect
    logic lo_prev; // Previous low carrier
    logic out; // Modulated output
    logic oe;
    logic slr;
    logic [4:0] hblk;
    logic [4:0] lblk;
    logic [7:0] mblk;
    logic [31:0] rdata;
    logic ready;
  } msc_st_t;
  msc_st_t st_q, st_d;

  // Power-on only state lives apart: carrier and source fields keep their value on other resets
  msc_pkg::msc_car_t carh_keep_q, carl_keep_q;
  msc_pkg::msc_src_t src_keep_q;

  logic hi_car, lo_car, mod_sig, hi_raw, lo_raw;
  logic setup, access;

  // Carrier muxes
  always_comb begin
    case (carh_keep_q.sel)
      msc_pkg::MSC_SEL_VSS: hi_raw = 1'b0;
      msc_pkg::MSC_SEL_PIN1: hi_raw = src_s.pin1;
      msc_pkg::MSC_SEL_PIN2: hi_raw = src_s.pin2;
      msc_pkg::MSC_SEL_REFCLK: hi_raw = src_s.refclk;
      msc_pkg::MSC_SEL_PWM: hi_raw = src_s.pwm;
      default: hi_raw = 1'b0; // Nothing connected
    endcase
    case (carl_keep_q.sel)
      msc_pkg::MSC_SEL_VSS: lo_raw = 1'b0;
      msc_pkg::MSC_SEL_PIN1: lo_raw = src_s.pin1;
      msc_pkg::MSC_SEL_REFCLK: lo_raw = src_s.refclk;
      msc_pkg::MSC_SEL_PWM: lo_raw = src_s.pwm;
      default: lo_raw = 1'b0; // Code 2 and above 4 connect nothing
    endcase
    hi_car = hi_raw ^ carh_keep_q.pol;
    lo_car = lo_raw ^ carl_keep_q.pol;
    case (src_keep_q.sel)
      msc_pkg::MSC_MS_SWBIT: mod_sig = st_q.con.swbit;
      msc_pkg::MSC_MS_PIN: mod_sig = src_s.mod_pin;
      msc_pkg::MSC_MS_PWM: mod_sig = src_s.pwm;
      msc_pkg::MSC_MS_CMP: mod_sig = src_s.cmp;
      msc_pkg::MSC_MS_SDO: mod_sig = src_s.sdo;
      msc_pkg::MSC_MS_TX: mod_sig = src_s.tx;
      default: mod_sig = 1'b0;
    endcase
  end

  assign setup = psel && !penable;
  assign access = psel && penable;

  // Next state
  always_comb begin
    logic car;
    car = 1'b0;
    st_d = st_q;
    st_d.carh = carh_keep_q;
    st_d.carl = carl_keep_q;
    st_d.src = src_keep_q;
    st_d.hi_prev = hi_car;
    st_d.lo_prev = lo_car;
    // Path switching with optional falling-edge wait
    if (mod_sig != st_q.use_high) begin
      if (st_q.use_high) begin
        if (!carh_keep_q.sync || (st_q.hi_prev && !hi_car)) begin
          st_d.use_high = 1'b0;
        end
      end else begin
        if (!carl_keep_q.sync || (st_q.lo_prev && !lo_car)) begin
          st_d.use_high = 1'b1;
        end
      end
    end
    // Output path: the switch takes effect on the same edge as the register update
    car = st_d.use_high ? hi_car : lo_car;
    st_d.out = st_q.con.en ? (car ^ st_q.con.opol) : 1'b0;
    st_d.oe = st_q.con.en && st_q.con.oe;
    st_d.slr = st_q.con.slr;
    // Pin blocks: one-hot on the selected source index, carrier codes 0 to 4 at the code, source codes 0 to 10 at half the code
    st_d.hblk = '0;
    st_d.lblk = '0;
    st_d.mblk = '0;
    if (carh_keep_q.odis && carh_keep_q.sel <= msc_pkg::MSC_SEL_PWM) begin
      st_d.hblk[carh_keep_q.sel[2:0]] = 1'b1;
    end
    if (carl_keep_q.odis && carl_keep_q.sel <= msc_pkg::MSC_SEL_PWM) begin
      st_d.lblk[carl_keep_q.sel[2:0]] = 1'b1;
    end
    if (src_keep_q.odis && src_keep_q.sel <= msc_pkg::MSC_MS_TX && src_keep_q.sel[3:1] != 3'h7) begin
      st_d.mblk[src_keep_q.sel[3:1]] = 1'b1;
    end
    // APB: answer one cycle after setup
    st_d.ready = setup;
    st_d.rdata = '0;
    if (setup && !pwrite) begin
      case (paddr)
        msc_pkg::MSC_OFF_CARH: st_d.rdata = {24'h000000, carh_keep_q.odis, carh_keep_q.pol,
          carh_keep_q.sync, 1'b0, carh_keep_q.sel};
        msc_pkg::MSC_OFF_CARL: st_d.rdata = {24'h000000, carl_keep_q.odis, carl_keep_q.pol,
          carl_keep_q.sync, 1'b0, carl_keep_q.sel};
        msc_pkg::MSC_OFF_CON: st_d.rdata = {24'h000000, st_q.con.en, st_q.con.oe, st_q.con.slr,
          st_q.con.opol, st_q.out, 2'b00, st_q.con.swbit};
        msc_pkg::MSC_OFF_SRC: st_d.rdata = {24'h000000, src_keep_q.odis, 3'b000, src_keep_q.sel};
        default: st_d.rdata = '0; // Unmapped reads zero
      endcase
    end
    if (access && st_q.ready && pwrite && paddr == msc_pkg::MSC_OFF_CON) begin
      st_d.con.en = pwdata[msc_pkg::MSC_CON_EN];
      st_d.con.oe = pwdata[msc_pkg::MSC_CON_OE];
      st_d.con.slr = pwdata[msc_pkg::MSC_CON_SLR];
      st_d.con.opol = pwdata[msc_pkg::MSC_CON_OPOL];
      st_d.con.swbit = pwdata[msc_pkg::MSC_CON_BIT];
    end
  end

  // Main registers; presetn alone resets control to MSC_CON_RST (slew limit set) and disables the module
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.con <= {msc_pkg::MSC_CON_RST[7:5], msc_pkg::MSC_CON_RST[4], msc_pkg::MSC_CON_RST[0]};
    end else begin
      st_q <= st_d;
    end
  end

  // Carrier and source fields: only power-on reset touches them, other resets leave them
  always_ff @(posedge pclk or negedge porn) begin
    if (!porn) begin
      carh_keep_q <= msc_pkg::MSC_CAR_RST[6:0];
      carl_keep_q <= msc_pkg::MSC_CAR_RST[6:0];
      src_keep_q <= msc_pkg::MSC_SRC_RST[4:0];
    end else if (presetn && psel && penable && st_q.ready && pwrite) begin
      if (paddr == msc_pkg::MSC_OFF_CARH) begin
        carh_keep_q <= {pwdata[7:5], pwdata[3:0]};
      end
      if (paddr == msc_pkg::MSC_OFF_CARL) begin
        carl_keep_q <= {pwdata[7:5], pwdata[3:0]};
      end
      if (paddr == msc_pkg::MSC_OFF_SRC) begin
        src_keep_q <= {pwdata[7], pwdata[3:0]};
      end
    end
  end

  // Outputs straight from flops; pslverr tied low
  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = 1'b0;
  assign modulated_out = st_q.out;
  assign modulator_pin_enable = st_q.oe;
  assign output_slew_limit = st_q.slr;
  assign hi_pin_block = st_q.hblk;
  assign lo_pin_block = st_q.lblk;
  assign mod_pin_block = st_q.mblk;

  // Checks
  a_disabled_silent: assert property (@(posedge pclk) disable iff (!presetn)
    !st_q.con.en |=> !modulated_out) else $error("output active while disabled");
  a_hi_sync_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q.use_high && carh_keep_q.sync && !(st_q.hi_prev && !hi_car)) |=> st_q.use_high)
    else $error("left high carrier without falling edge");
  a_lo_sync_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!st_q.use_high && carl_keep_q.sync && !(st_q.lo_prev && !lo_car)) |=> !st_q.use_high)
    else $error("left low carrier without falling edge");
  a_nosync_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q.use_high ? !carh_keep_q.sync : !carl_keep_q.sync) |=> st_q.use_high == $past(mod_sig))
    else $error("unsynced path did not follow modulation");
  a_out_path: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.con.en |=> modulated_out == (($past(st_d.use_high) ? $past(hi_car) : $past(lo_car)) ^ $past(st_q.con.opol)))
    else $error("output not from selected path");
  a_hi_block: assert property (@(posedge pclk) disable iff (!presetn)
    (carh_keep_q.odis && carh_keep_q.sel == msc_pkg::MSC_SEL_PWM) |=> hi_pin_block[4])
    else $error("high peripheral pin not blocked");
  a_lo_block: assert property (@(posedge pclk) disable iff (!presetn)
    !carl_keep_q.odis |=> lo_pin_block == 5'h00) else $error("low pin blocked while enabled");
  a_read_bit4: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == msc_pkg::MSC_OFF_CARH) |=> pready && !prdata[4])
    else $error("carrier read answer wrong");
  a_reset_off: assert property (@(posedge pclk) $rose(presetn) |-> !st_q.con.en)
    else $error("module enabled after reset");
endmodule // msc_top
`default_nettype wire

// ===== sim/msc_src_model.sv
// Model of the carrier and modulation sources that feed the carrier-select block.
// Assumes the bench sets pin levels; the reference clock and PWM carriers run free here.
`default_nettype none
module msc_src_model (
  input wire logic pclk,
  input wire msc_pkg::msc_src_in_t lvl,
  output msc_pkg::msc_src_in_t src
);
  timeunit 1ns;
  timeprecision 100ps;
  // Free-running divider; refclk and pwm have different rates so a wrong select shows
  logic [3:0] div_q = 4'h0;
  always @(posedge pclk) begin
    div_q <= div_q + 4'h1;
  end
  // Pins pass as the bench drives them; on-chip carriers come from the divider
  always_comb begin
    src = lvl;
    src.refclk = div_q[2];
    src.pwm = div_q[3];
  end
endmodule // msc_src_model
`default_nettype wire

// ===== sim/msc_top_test.sv
// Self-checking bench for the carrier-select block: register access, muxing, sync switching, resets.
// Assumes the block raises pready by itself (waited for with a bound) and carriers cross a short synchroniser.
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module msc_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic porn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, modulated_out, modulator_pin_enable, output_slew_limit;
  logic pslverr, errv; // Error response and its value taken at the answering edge
  logic [4:0] hi_pin_block, lo_pin_block;
  logic [7:0] mod_pin_block, rdv;
  msc_pkg::msc_src_in_t lvl = '0;
  msc_pkg::msc_src_in_t src;
  int bad_count = 0;
  int checks_done = 0;
  // Carrier code tables and the level each should give with both pins held high
  logic [3:0] hc [5] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'hF};
  logic he [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [3:0] lc [4] = '{4'h0, 4'h1, 4'h2, 4'h5};
  logic le [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  localparam logic [11:0] CARH = msc_pkg::MSC_OFF_CARH;
  localparam logic [11:0] CARL = msc_pkg::MSC_OFF_CARL;
  localparam logic [11:0] CON = msc_pkg::MSC_OFF_CON;
  localparam logic [11:0] SRC = msc_pkg::MSC_OFF_SRC;
  initial begin
    forever #5 pclk = ~pclk;
  end
  msc_src_model msc_src_model_i (.pclk(pclk), .lvl(lvl), .src(src));
  msc_top msc_top_i (.pclk(pclk), .presetn(presetn), .porn(porn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_in(src), .modulated_out(modulated_out), .modulator_pin_enable(modulator_pin_enable),
    .output_slew_limit(output_slew_limit), .hi_pin_block(hi_pin_block), .lo_pin_block(lo_pin_block),
    .mod_pin_block(mod_pin_block));
  // Verdict; also reached when the watchdog fires
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One APB transfer; the request stands until the rising edge at which pready is seen high,
  // and read data and error are taken at that same edge, before the block's own update lands
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      wrap_up();
    end else begin
      rdv = prdata[7:0];
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  // Bounded wait for the output to settle, covering the carrier synchroniser lag;
  // two cycles pass first so a stale level cannot satisfy the check before a write lands
  task automatic expect_out(input logic e);
    int n;
    n = 0;
    repeat (2) @(negedge pclk);
    while (modulated_out !== e && n < 20) begin
      @(negedge pclk);
      n++;
    end
    `CHK("modulated_out", e, modulated_out)
  endtask
  // A free-running carrier must toggle the output at its own rate, so a wrong source shows
  task automatic expect_toggles(input int lo, input int hi);
    int t;
    logic last;
    t = 0;
    last = modulated_out;
    repeat (48) begin
      @(negedge pclk);
      if (modulated_out !== last) t++;
      last = modulated_out;
    end
    `CHK("toggles", 1'b1, t >= lo && t <= hi)
  endtask
  // Control reset value, unimplemented bits, unmapped space
  task automatic t_regs;
    rd(CON); `CHK("con", 8'h20, rdv)
    wr(CARH, 8'hFF); rd(CARH); `CHK("carh", 8'hEF, rdv)
    wr(CARL, 8'hFF); rd(CARL); `CHK("carl", 8'hEF, rdv)
    wr(SRC, 8'hFF); rd(SRC); `CHK("src", 8'h8F, rdv)
    rd(12'h010); `CHK("unmapped", 8'h00, rdv)
    `CHK("pslverr", 1'b0, errv)
  endtask
  // Pin-disable outputs follow the selected code only while the disable bit is set
  task automatic t_pinblock;
    wr(CARH, 8'h82); wr(CARL, 8'h84); wr(SRC, 8'h88);
    repeat (2) @(negedge pclk);
    `CHK("hi_block", 5'h04, hi_pin_block)
    `CHK("lo_block", 5'h10, lo_pin_block)
    `CHK("mod_block", 8'h10, mod_pin_block)
    wr(CARH, 8'h84);
    repeat (2) @(negedge pclk);
    `CHK("hi_block_pwm", 5'h10, hi_pin_block)
    wr(CARH, 8'h02); wr(CARL, 8'h04); wr(SRC, 8'h00);
    repeat (2) @(negedge pclk);
    `CHK("hi_block", 5'h00, hi_pin_block)
    `CHK("lo_block", 5'h00, lo_pin_block)
  endtask
  // High codes 0, 1, 2, 5, 15 and low codes 0, 1, 2, 5, then the two free-running carriers on the high path
  task automatic t_select;
    wr(CARL, 8'h00); wr(CON, 8'h81);
    for (int i = 0; i < 5; i++) begin
      wr(CARH, {4'h0, hc[i]}); expect_out(he[i]);
    end
    wr(CON, 8'h80);
    for (int i = 0; i < 4; i++) begin
      wr(CARL, {4'h0, lc[i]}); expect_out(le[i]);
    end
    wr(CARH, 8'h03); wr(CON, 8'h81); expect_toggles(10, 13);
    wr(CARH, 8'h04); expect_toggles(4, 7);
  endtask
  // Path selection, carrier inversion, output inversion, enable
  task automatic t_path;
    wr(CARH, 8'h01); wr(CARL, 8'h00); wr(CON, 8'h81); expect_out(1'b1);
    rd(CON); `CHK("con_out", 8'h89, rdv)
    wr(CON, 8'h80); expect_out(1'b0);
    wr(CARL, 8'h40); expect_out(1'b1);
    wr(CON, 8'h81); wr(CARH, 8'h41); expect_out(1'b0);
    wr(CON, 8'h91); expect_out(1'b1);
    wr(CON, 8'h11); expect_out(1'b0);
    wr(CON, 8'hC0); repeat (2) @(negedge pclk);
    `CHK("pin_en", 1'b1, modulator_pin_enable)
    `CHK("slew", 1'b0, output_slew_limit)
  endtask
  // Modulation source select: pin, comparator, reserved code, transmit line
  task automatic t_source;
    wr(CARH, 8'h01); wr(CARL, 8'h00); wr(CON, 8'h80);
    @(posedge pclk) lvl.mod_pin <= 1'b1;
    wr(SRC, 8'h01); expect_out(1'b1);
    wr(SRC, 8'h06); expect_out(1'b0);
    @(posedge pclk) lvl.cmp <= 1'b1;
    expect_out(1'b1);
    wr(SRC, 8'h05); expect_out(1'b0);
    @(posedge pclk) lvl.tx <= 1'b1;
    wr(SRC, 8'h0A); expect_out(1'b1);
    wr(SRC, 8'h00);
  endtask
  // Switch held until the outgoing carrier falls; immediate without sync
  task automatic t_sync;
    wr(CARL, 8'h00); wr(CARH, 8'h21); wr(CON, 8'h81); expect_out(1'b1);
    wr(CON, 8'h80); repeat (12) @(negedge pclk);
    `CHK("hold_hi", 1'b1, modulated_out)
    @(posedge pclk) lvl.pin1 <= 1'b0;
    expect_out(1'b0);
    @(posedge pclk) lvl.pin1 <= 1'b1;
    repeat (8) @(negedge pclk);
    `CHK("after_hi", 1'b0, modulated_out)
    wr(CARH, 8'h00); wr(CARL, 8'h21); expect_out(1'b1);
    wr(CON, 8'h81); repeat (12) @(negedge pclk);
    `CHK("hold_lo", 1'b1, modulated_out)
    @(posedge pclk) lvl.pin1 <= 1'b0;
    expect_out(1'b0);
    @(posedge pclk) lvl.pin1 <= 1'b1;
    repeat (8) @(negedge pclk);
    `CHK("after_lo", 1'b0, modulated_out)
    wr(CARL, 8'h01); wr(CON, 8'h80); expect_out(1'b1);
    wr(CON, 8'h81); repeat (4) @(negedge pclk);
    `CHK("no_sync", 1'b0, modulated_out)
  endtask
  // Ordinary reset returns control to its reset value (slew limit set) but keeps the carrier setup
  task automatic t_reset;
    wr(CARH, 8'hA3); wr(CON, 8'h81);
    @(posedge pclk) presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    `CHK("out_rst", 1'b0, modulated_out)
    rd(CARH); `CHK("carh_kept", 8'hA3, rdv)
    rd(CON); `CHK("con_rst", 8'h20, rdv)
    `CHK("slew_rst", 1'b1, output_slew_limit)
  endtask
  // Watchdog: a hang counts as a mismatch
  initial begin
    #500000;
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    porn <= 1'b1;
    lvl.pin1 <= 1'b1;
    lvl.pin2 <= 1'b1;
    t_regs();
    t_pinblock();
    t_select();
    t_path();
    t_source();
    t_sync();
    t_reset();
    wrap_up();
  end
endmodule // msc_top_test
`default_nettype wire
